// ==== wfbf_checker.sv ====
/*
 * Checker for the word link between the framer ends.
 * Assumes one clock and the link signals as plain inputs.
 */
`timescale 1ns/1ns
module wfbf_checker
(
	// Clock and reset
	input wire logic        clock,
	input wire logic        rst_n,
	// Link
	input wire logic [31:0] word,
	input wire logic        valid,
	input wire logic        ready
);
	// ========================================
	// Stream position tracking
	// One type digit per transfer index, index 0 first
	localparam logic [167:0] TYPES = {8'h04, 48'h333333333333, 8'h11,
		56'h31313131313131, 48'h424242422224};
	logic       take, lo, fld_lo, blk_lo, end_lo;
	logic       hi_q, hi_d, two_q, two_d, in_q, in_d, emp_q, emp_d, gap_q, gap_d;
	logic [5:0] cnt_q, cnt_d;
	logic [2:0] exp_typ;

	always_comb
	begin
		take    = valid && ready;
		lo      = take && hi_q;
		fld_lo  = lo && (word == wfbf_pkg::WFBF_FIELD_ONE_LO ||
			word == wfbf_pkg::WFBF_FIELD_TWO_LO);
		blk_lo  = lo && word[31:24] >= 8'h44 && word[31:24] <= 8'h48 && word[23:0] == 24'h000000;
		end_lo  = lo && word == wfbf_pkg::WFBF_SEQ_END_LO;
		exp_typ = 3'h0;
		// Guarded so an overlong field cannot index past the table
		if (cnt_q < 6'h29)
			exp_typ = TYPES[(40 - int'(cnt_q)) * 4 +: 3];
		hi_d  = take ? word == wfbf_pkg::WFBF_DELIM_HI : hi_q;
		two_d = fld_lo ? ~word[24] : (end_lo ? 1'b0 : two_q);
		in_d  = fld_lo | (in_q & ~end_lo);
		cnt_d = fld_lo ? 6'h00 : cnt_q + {5'h00, blk_lo};
		emp_d = take ? lo && word == wfbf_pkg::WFBF_EMPTY_BLOCK_LO : emp_q;
		gap_d = take ? emp_q : gap_q;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{hi_q, two_q, in_q, emp_q, gap_q} <= 5'h00;
			cnt_q <= 6'h00;
		end
		else
		begin
			{hi_q, two_q, in_q, emp_q, gap_q} <= {hi_d, two_d, in_d, emp_d, gap_d};
			cnt_q <= cnt_d;
		end
	end

	// ========================================
	// Properties
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	AST_HOLD: assert property (valid && !ready |=> valid && $stable(word))
		else $error("link word changed before it was taken");
	AST_PAIR: assert property (take && word == wfbf_pkg::WFBF_DELIM_HI |=> take && (fld_lo || blk_lo || end_lo))
		else $error("delimiter not completed by a known code word");
	AST_TC_TOP: assert property (fld_lo |=> take && word[31:26] == 6'h00)
		else $error("timecode top word carries more than 90 bits");
	AST_TYPE_CODE: assert property (fld_lo |=> take [*3] ##1 take && word[31:24] == 8'h83 && word[7:0] == 8'h00)
		else $error("first block type code missing after timecode");
	AST_BW_WORD: assert property (blk_lo |=> take && word[15:0] == 16'h0000)
		else $error("bin width word malformed after block code");
	AST_ALTERNATE: assert property (fld_lo |-> word[24] == two_q)
		else $error("field codes do not alternate");
	AST_COUNT: assert property ((fld_lo || end_lo) && in_q |-> cnt_q == 6'h29)
		else $error("field closed without 41 blocks");
	AST_INSIDE: assert property (blk_lo |-> in_q && cnt_q < 6'h29)
		else $error("block code outside a field");
	AST_ORDER: assert property (blk_lo && word != wfbf_pkg::WFBF_EMPTY_BLOCK_LO |-> word[31:24] == 8'h43 + {5'h00, exp_typ})
		else $error("block code type wrong for its position");
	AST_EMPTY: assert property (take && gap_q |-> word == wfbf_pkg::WFBF_DELIM_HI)
		else $error("empty block followed by data");

	COV_TWO: cover property (fld_lo && word[24]);
	COV_EMPTY: cover property (take && emp_q);
	COV_END: cover property (end_lo && cnt_q == 6'h29);
endmodule

// ==== wfbf_dev.sv ====
/*
 * Device end: parses the incoming field stream and checks its structure.
 * Assumes coded data words never hold an all-ones word, which is read as a delimiter.
 */
`timescale 1ns/1ns
module wfbf_dev
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// Link
	wfbf_link_if.dev         link,
	// Field events
	output logic             dec_restart,
	output logic             field_start,
	output logic             field_two,
	output logic             field_done,
	output logic             seq_end,
	// Timecode
	output logic [89:0]      timecode,
	output logic             tc_valid,
	// Block header
	output logic             blk_start,
	output logic [5:0]       blk_num,
	output logic [15:0]      blk_bw,
	output logic             blk_empty,
	// Coded data
	output logic [31:0]      data_word,
	output logic             data_valid,
	// Errors
	output logic             frame_err
);
	// ========================================================
	// State
	typedef enum logic [2:0] {D_HUNT, D_DLO, D_TC, D_TYPE, D_BW, D_DATA} wfbf_dst_t;

	wfbf_dst_t   st_q, st_d;
	logic        rdy_q, take;
	logic        restart_q, restart_d, fstart_q, fstart_d, two_q, two_d;
	logic        fdone_q, fdone_d, send_q, send_d, tcv_q, tcv_d;
	logic        bstart_q, bstart_d, empty_q, empty_d, dval_q, dval_d;
	logic        err_q, err_d, infield_q, infield_d, seen_q, seen_d;
	logic [95:0] tcsh_q, tcsh_d;
	logic [89:0] tc_q, tc_d;
	logic [1:0]  cnt_q, cnt_d;
	logic [5:0]  idx_q, idx_d, bnum_q, bnum_d;
	logic [15:0] bw_q, bw_d;
	logic [31:0] dw_q, dw_d;
	logic [8:0]  entry;
	logic [5:0]  nidx;

	// Second delimiter word names a block start of any type
	function automatic logic is_block_lo(input logic [31:0] w);
		return (w == wfbf_pkg::WFBF_BLOCK_TYPE_ONE_LO) || (w == wfbf_pkg::WFBF_BLOCK_TYPE_TWO_LO)
			|| (w == wfbf_pkg::WFBF_BLOCK_TYPE_THR_LO) || (w == wfbf_pkg::WFBF_BLOCK_TYPE_FOU_LO)
			|| (w == wfbf_pkg::WFBF_EMPTY_BLOCK_LO);
	endfunction

	// ========================================================
	// Next state
	always_comb
	begin
		st_d      = st_q;
		restart_d = 1'b0;
		fstart_d  = 1'b0;
		fdone_d   = 1'b0;
		send_d    = 1'b0;
		tcv_d     = 1'b0;
		bstart_d  = 1'b0;
		dval_d    = 1'b0;
		err_d     = 1'b0;
		two_d     = two_q;
		empty_d   = empty_q;
		infield_d = infield_q;
		seen_d    = seen_q;
		tcsh_d    = tcsh_q;
		tc_d      = tc_q;
		cnt_d     = cnt_q;
		idx_d     = idx_q;
		bnum_d    = bnum_q;
		bw_d      = bw_q;
		dw_d      = dw_q;
		take      = link.valid && rdy_q;
		nidx      = idx_q + 6'h01;
		entry     = wfbf_pkg::wfbf_block_entry(nidx);
		if (take)
		begin
			case (st_q)
				D_HUNT:
					// Delimiters are only looked for on word boundaries
					if (link.word == wfbf_pkg::WFBF_DELIM_HI)
						st_d = D_DLO;
				D_DLO:
				begin
					st_d = D_HUNT;
					if (infield_q && idx_q == wfbf_pkg::WFBF_LAST_IDX)
						fdone_d = 1'b1;
					if (link.word == wfbf_pkg::WFBF_FIELD_ONE_LO
						|| link.word == wfbf_pkg::WFBF_FIELD_TWO_LO)
					begin
						two_d     = (link.word == wfbf_pkg::WFBF_FIELD_TWO_LO);
						// Field one start alone restarts the whole chain
						restart_d = !two_d;
						// Same field twice in a row breaks the odd/even pairing
						if (seen_q && two_d == two_q)
							err_d = 1'b1;
						// A field cut short before its last block
						if (infield_q && idx_q != wfbf_pkg::WFBF_LAST_IDX)
							err_d = 1'b1;
						fstart_d  = 1'b1;
						infield_d = 1'b1;
						seen_d    = 1'b1;
						idx_d     = 6'h00;
						cnt_d     = 2'h0;
						st_d      = D_TC;
					end
					else if (link.word == wfbf_pkg::WFBF_SEQ_END_LO)
					begin
						if (infield_q && idx_q != wfbf_pkg::WFBF_LAST_IDX)
							err_d = 1'b1;
						send_d    = 1'b1;
						infield_d = 1'b0;
						seen_d    = 1'b0;
					end
					else if (is_block_lo(link.word))
					begin
						if (!infield_q || idx_q == wfbf_pkg::WFBF_LAST_IDX)
							err_d = 1'b1;
						else
						begin
							empty_d = (link.word == wfbf_pkg::WFBF_EMPTY_BLOCK_LO);
							// Type must match the fixed transfer order
							if (!empty_d
								&& link.word != wfbf_pkg::wfbf_block_lo(entry[8:6]))
								err_d = 1'b1;
							idx_d  = nidx;
							bnum_d = entry[5:0];
							st_d   = D_BW;
						end
					end
					else
						err_d = 1'b1;
				end
				D_TC:
				begin
					tcsh_d = {tcsh_q[63:0], link.word};
					cnt_d  = cnt_q + 2'h1;
					if (cnt_q == wfbf_pkg::WFBF_TC_LAST_CNT)
					begin
						// Top six bits of the twelve bytes carry nothing
						tc_d  = tcsh_d[wfbf_pkg::WFBF_TC_BITS-1:0];
						tcv_d = 1'b1;
						st_d  = D_TYPE;
					end
				end
				D_TYPE:
				begin
					if (link.word[31:24] != wfbf_pkg::WFBF_FIRST_TYPE_CODE)
						err_d = 1'b1;
					bw_d     = link.word[23:8];
					bnum_d   = wfbf_pkg::WFBF_FIRST_BLOCK;
					empty_d  = 1'b0;
					bstart_d = 1'b1;
					st_d     = D_DATA;
				end
				D_BW:
				begin
					bw_d     = link.word[31:16];
					bstart_d = 1'b1;
					// An empty block carries no data; stray words are skipped while hunting
					st_d     = empty_q ? D_HUNT : D_DATA;
				end
				D_DATA:
					if (link.word == wfbf_pkg::WFBF_DELIM_HI)
						st_d = D_DLO;
					else
					begin
						dw_d   = link.word;
						dval_d = 1'b1;
					end
				default: st_d = D_HUNT;
			endcase
		end
	end

	// ========================================================
	// Registers
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q      <= D_HUNT;
			rdy_q     <= 1'b0;
			restart_q <= 1'b0;
			fstart_q  <= 1'b0;
			two_q     <= 1'b0;
			fdone_q   <= 1'b0;
			send_q    <= 1'b0;
			tcv_q     <= 1'b0;
			bstart_q  <= 1'b0;
			empty_q   <= 1'b0;
			dval_q    <= 1'b0;
			err_q     <= 1'b0;
			infield_q <= 1'b0;
			seen_q    <= 1'b0;
			tcsh_q    <= 96'h0;
			tc_q      <= 90'h0;
			cnt_q     <= 2'h0;
			idx_q     <= 6'h00;
			bnum_q    <= 6'h00;
			bw_q      <= 16'h0000;
			dw_q      <= 32'h00000000;
		end
		else if (ce)
		begin
			st_q      <= st_d;
			rdy_q     <= 1'b1;
			restart_q <= restart_d;
			fstart_q  <= fstart_d;
			two_q     <= two_d;
			fdone_q   <= fdone_d;
			send_q    <= send_d;
			tcv_q     <= tcv_d;
			bstart_q  <= bstart_d;
			empty_q   <= empty_d;
			dval_q    <= dval_d;
			err_q     <= err_d;
			infield_q <= infield_d;
			seen_q    <= seen_d;
			tcsh_q    <= tcsh_d;
			tc_q      <= tc_d;
			cnt_q     <= cnt_d;
			idx_q     <= idx_d;
			bnum_q    <= bnum_d;
			bw_q      <= bw_d;
			dw_q      <= dw_d;
		end
	end

	// ========================================================
	// Outputs
	assign link.ready  = rdy_q;
	assign dec_restart = restart_q;
	assign field_start = fstart_q;
	assign field_two   = two_q;
	assign field_done  = fdone_q;
	assign seq_end     = send_q;
	assign timecode    = tc_q;
	assign tc_valid    = tcv_q;
	assign blk_start   = bstart_q;
	assign blk_num     = bnum_q;
	assign blk_bw      = bw_q;
	assign blk_empty   = empty_q;
	assign data_word   = dw_q;
	assign data_valid  = dval_q;
	assign frame_err   = err_q;
endmodule

// ==== wfbf_host.sv ====
/*
 * Stream source end: builds fields and the closing code word by word.
 * Assumes the user holds bin width and empty flag steady for cur_block.
 */
`timescale 1ns/1ns
module wfbf_host
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// Link
	wfbf_link_if.host        link,
	// Commands
	input  wire logic        field_go,
	input  wire logic        end_go,
	input  wire logic [89:0] timecode,
	// Block header data
	input  wire logic [15:0] blk_bw,
	input  wire logic        blk_empty,
	// Coded data
	input  wire logic [31:0] data_word,
	input  wire logic        data_valid,
	input  wire logic        data_last,
	output logic             data_ready,
	// Status
	output logic [5:0]       cur_block,
	output logic             busy,
	output logic             next_field_two
);
	// ========================================================
	// State
	typedef enum logic [3:0] {H_IDLE, H_FHI, H_FLO, H_TC, H_TYPE, H_DATA,
		H_SHI, H_SLO, H_BW, H_EHI, H_ELO} wfbf_hst_t;

	wfbf_hst_t   st_q, st_d;
	logic [31:0] word_q, word_d;
	logic        valid_q, valid_d, rdy_q, rdy_d, two_q, two_d;
	logic        empty_q, empty_d, busy_q, busy_d, load, adv;
	logic [95:0] tc_q, tc_d;
	logic [1:0]  cnt_q, cnt_d;
	logic [5:0]  idx_q, idx_d, blk_q, blk_d;
	logic [8:0]  entry, nentry;

	// ========================================================
	// Next state
	always_comb
	begin
		st_d    = st_q;
		word_d  = word_q;
		valid_d = valid_q;
		two_d   = two_q;
		empty_d = empty_q;
		busy_d  = busy_q;
		tc_d    = tc_q;
		cnt_d   = cnt_q;
		idx_d   = idx_q;
		adv     = 1'b0;
		load    = !valid_q || link.ready;
		entry   = wfbf_pkg::wfbf_block_entry(idx_q);
		if (valid_q && link.ready)
			valid_d = 1'b0;
		case (st_q)
			H_IDLE:
			begin
				busy_d = 1'b0;
				if (field_go)
				begin
					tc_d   = {6'h00, timecode};
					idx_d  = 6'h00;
					busy_d = 1'b1;
					st_d   = H_FHI;
				end
				else if (end_go)
				begin
					busy_d = 1'b1;
					st_d   = H_EHI;
				end
			end
			H_FHI, H_SHI, H_EHI:
				if (load)
				begin
					word_d  = wfbf_pkg::WFBF_DELIM_HI;
					valid_d = 1'b1;
					st_d    = (st_q == H_FHI) ? H_FLO : (st_q == H_SHI) ? H_SLO : H_ELO;
				end
			H_FLO:
				if (load)
				begin
					// Odd field then even field, alternating until an end code sets it back to odd
					word_d  = two_q ? wfbf_pkg::WFBF_FIELD_TWO_LO
						: wfbf_pkg::WFBF_FIELD_ONE_LO;
					valid_d = 1'b1;
					two_d   = !two_q;
					cnt_d   = 2'h0;
					st_d    = H_TC;
				end
			H_TC:
				if (load)
				begin
					word_d  = tc_q[95:64];
					valid_d = 1'b1;
					tc_d    = {tc_q[63:0], 32'h00000000};
					cnt_d   = cnt_q + 2'h1;
					if (cnt_q == wfbf_pkg::WFBF_TC_LAST_CNT)
						st_d = H_TYPE;
				end
			H_TYPE:
				if (load)
				begin
					// First block has no delimiter, only the type code
					word_d  = {wfbf_pkg::WFBF_FIRST_TYPE_CODE, blk_bw,
						wfbf_pkg::WFBF_TYPE_PAD};
					valid_d = 1'b1;
					st_d    = H_DATA;
				end
			H_SLO:
				if (load)
				begin
					// Taken a cycle after cur_block moves, so a registered user keeps up
					empty_d = blk_empty;
					word_d  = blk_empty ? wfbf_pkg::WFBF_EMPTY_BLOCK_LO
						: wfbf_pkg::wfbf_block_lo(entry[8:6]);
					valid_d = 1'b1;
					st_d    = H_BW;
				end
			H_BW:
				if (load)
				begin
					word_d  = {blk_bw, wfbf_pkg::WFBF_BW_PAD};
					valid_d = 1'b1;
					st_d    = H_DATA;
					adv     = empty_q;
				end
			H_DATA:
				if (data_valid && rdy_q)
				begin
					word_d  = data_word;
					valid_d = 1'b1;
					adv     = data_last;
				end
			H_ELO:
				if (load)
				begin
					word_d  = wfbf_pkg::WFBF_SEQ_END_LO;
					valid_d = 1'b1;
					two_d   = 1'b0;
					st_d    = H_IDLE;
				end
			default: st_d = H_IDLE;
		endcase
		if (adv)
		begin
			// 41 delimited blocks follow the first one
			if (idx_q == wfbf_pkg::WFBF_LAST_IDX)
				st_d = H_IDLE;
			else
			begin
				idx_d = idx_q + 6'h01;
				st_d  = H_SHI;
			end
		end
		nentry = wfbf_pkg::wfbf_block_entry(idx_d);
		blk_d  = nentry[5:0];
		// Half rate in data: ready only once the word slot has drained, no skid needed
		rdy_d = (st_d == H_DATA) && !valid_d;
	end

	// ========================================================
	// Registers
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q    <= H_IDLE;
			word_q  <= 32'h00000000;
			valid_q <= 1'b0;
			rdy_q   <= 1'b0;
			two_q   <= 1'b0;
			empty_q <= 1'b0;
			busy_q  <= 1'b0;
			tc_q    <= 96'h0;
			cnt_q   <= 2'h0;
			idx_q   <= 6'h00;
			blk_q   <= 6'h06;
		end
		else if (ce)
		begin
			st_q    <= st_d;
			word_q  <= word_d;
			valid_q <= valid_d;
			rdy_q   <= rdy_d;
			two_q   <= two_d;
			empty_q <= empty_d;
			busy_q  <= busy_d;
			tc_q    <= tc_d;
			cnt_q   <= cnt_d;
			idx_q   <= idx_d;
			blk_q   <= blk_d;
		end
	end

	assign link.word      = word_q;
	assign link.valid     = valid_q;
	assign data_ready     = rdy_q;
	assign cur_block      = blk_q;
	assign busy           = busy_q;
	assign next_field_two = two_q;
endmodule

// ==== wfbf_link_if.sv ====
/*
 * Word link between the stream source (host) and the parsing device.
 * Assumes one clock for both ends; valid/ready handshake per word.
 */
`timescale 1ns/1ns
interface wfbf_link_if
(
	input wire logic clock,
	input wire logic rst_n
);
	logic [31:0] word;
	logic        valid;
	logic        ready;

	modport dev
	(
		input  word,
		input  valid,
		output ready
	);

	modport host
	(
		output word,
		output valid,
		input  ready
	);
endinterface

// ==== wfbf_pkg.sv ====
/*
 * Shared constants and lookups for the field bitstream framer pair.
 * Assumes both ends exchange the stream as aligned 32-bit words.
 */
package wfbf_pkg;

	// ========================================================
	// Delimiters (all 64-bit, two aligned words)
	localparam logic [31:0] WFBF_DELIM_HI          = 32'hFFFFFFFF;
	localparam logic [31:0] WFBF_FIELD_ONE_LO      = 32'h40000000;
	localparam logic [31:0] WFBF_FIELD_TWO_LO      = 32'h41000000;
	localparam logic [31:0] WFBF_BLOCK_TYPE_ONE_LO = 32'h44000000;
	localparam logic [31:0] WFBF_BLOCK_TYPE_TWO_LO = 32'h45000000;
	localparam logic [31:0] WFBF_BLOCK_TYPE_THR_LO = 32'h46000000;
	localparam logic [31:0] WFBF_BLOCK_TYPE_FOU_LO = 32'h47000000;
	localparam logic [31:0] WFBF_EMPTY_BLOCK_LO    = 32'h48000000;
	localparam logic [31:0] WFBF_SEQ_END_LO        = 32'h4F000000;

	// ========================================================
	// Field layout
	localparam logic [7:0]  WFBF_FIRST_TYPE_CODE = 8'h83;
	localparam int          WFBF_TC_BITS         = 90;
	localparam int          WFBF_TC_WORDS        = 3;
	localparam logic [1:0]  WFBF_TC_LAST_CNT     = 2'h2;
	localparam logic [5:0]  WFBF_LAST_IDX        = 6'h29;
	localparam logic [5:0]  WFBF_FIRST_BLOCK     = 6'h06;
	localparam logic [15:0] WFBF_BW_PAD          = 16'h0000;
	localparam logic [7:0]  WFBF_TYPE_PAD        = 8'h00;

	// ========================================================
	// Transfer order: index -> {type, block number}; type 0 is the first block
	function automatic logic [8:0] wfbf_block_entry(input logic [5:0] idx);
		logic [8:0] r;
		r = 9'h000;
		case (idx)
			6'h00: r = {3'h0, 6'h06};
			6'h01: r = {3'h4, 6'h09};
			6'h02: r = {3'h3, 6'h14};
			6'h03: r = {3'h3, 6'h16};
			6'h04: r = {3'h3, 6'h13};
			6'h05: r = {3'h3, 6'h17};
			6'h06: r = {3'h3, 6'h11};
			6'h07: r = {3'h3, 6'h19};
			6'h08: r = {3'h3, 6'h10};
			6'h09: r = {3'h3, 6'h1A};
			6'h0A: r = {3'h3, 6'h0E};
			6'h0B: r = {3'h3, 6'h1C};
			6'h0C: r = {3'h3, 6'h0D};
			6'h0D: r = {3'h3, 6'h1D};
			6'h0E: r = {3'h1, 6'h0B};
			6'h0F: r = {3'h1, 6'h1F};
			6'h10: r = {3'h3, 6'h0A};
			6'h11: r = {3'h1, 6'h20};
			6'h12: r = {3'h3, 6'h08};
			6'h13: r = {3'h1, 6'h22};
			6'h14: r = {3'h3, 6'h07};
			6'h15: r = {3'h1, 6'h23};
			6'h16: r = {3'h3, 6'h05};
			6'h17: r = {3'h1, 6'h25};
			6'h18: r = {3'h3, 6'h04};
			6'h19: r = {3'h1, 6'h26};
			6'h1A: r = {3'h3, 6'h02};
			6'h1B: r = {3'h1, 6'h28};
			6'h1C: r = {3'h3, 6'h01};
			6'h1D: r = {3'h1, 6'h29};
			6'h1E: r = {3'h4, 6'h00};
			6'h1F: r = {3'h2, 6'h27};
			6'h20: r = {3'h4, 6'h0C};
			6'h21: r = {3'h2, 6'h24};
			6'h22: r = {3'h4, 6'h0F};
			6'h23: r = {3'h2, 6'h21};
			6'h24: r = {3'h4, 6'h12};
			6'h25: r = {3'h2, 6'h1E};
			6'h26: r = {3'h2, 6'h15};
			6'h27: r = {3'h2, 6'h1B};
			6'h28: r = {3'h2, 6'h18};
			6'h29: r = {3'h4, 6'h03};
			default: r = 9'h000;
		endcase
		return r;
	endfunction

	// Second delimiter word for a block type
	function automatic logic [31:0] wfbf_block_lo(input logic [2:0] typ);
		logic [31:0] r;
		r = WFBF_EMPTY_BLOCK_LO;
		case (typ)
			3'h1: r = WFBF_BLOCK_TYPE_ONE_LO;
			3'h2: r = WFBF_BLOCK_TYPE_TWO_LO;
			3'h3: r = WFBF_BLOCK_TYPE_THR_LO;
			3'h4: r = WFBF_BLOCK_TYPE_FOU_LO;
			default: r = WFBF_EMPTY_BLOCK_LO;
		endcase
		return r;
	endfunction

endpackage

// ==== wfbf_tb.sv ====
/*
 * Testbench: host end feeds the device end over the word link.
 * Assumes one clock; a second device gets a hand-made faulty stream.
 */
`timescale 1ns/1ns
module wfbf_tb;
	// ========================================
	// Stimulus and expectation state
	localparam logic [335:0] NUMS = {48'h060914161317, 48'h1119101A0E1C, 48'h0D1D0B1F0A20,
		48'h082207230525, 48'h042602280129, 48'h00270C240F21, 48'h121E151B1803};
	logic        clock   = 1'b0;
	logic        rst_n   = 1'b0;
	logic        field_go = 1'b0;
	logic        end_go  = 1'b0;
	logic [89:0] h_tc    = 90'h0;
	logic [15:0] h_bw    = 16'h0000;
	logic        h_empty = 1'b0;
	logic [31:0] h_data  = 32'h00000000;
	logic        h_valid = 1'b0;
	logic        h_last  = 1'b0;
	logic [31:0] rng     = 32'h0000004C;
	logic [31:0] base    = 32'h00000000;
	logic [31:0] r;
	logic [89:0] tc_exp  = 90'h0;
	logic [31:0] sent[$];
	logic [31:0] bad[4]  = '{32'hFFFFFFFF, 32'h44000000, 32'hFFFFFFFF, 32'h40000000};
	logic        two_exp = 1'b0;
	logic        hx      = 1'b0;
	logic        empty_exp = 1'b0;
	logic [5:0]  n;
	int          idx = 0, k, n_done = 0, n_end = 0, n_err2 = 0, n_rst2 = 0;
	int          errors = 0, n_checks = 0;
	logic        data_ready, busy, next_field_two, dec_restart, field_start, field_two;
	logic        field_done, seq_end, tc_valid, blk_start, d_empty, d_valid, frame_err;
	logic        err2, rst2;
	logic [5:0]  cur_block, blk_num;
	logic [89:0] d_tc;
	logic [15:0] d_bw;
	logic [31:0] d_data;

	always #10 clock = ~clock;

	wfbf_link_if link (.clock(clock), .rst_n(rst_n));
	wfbf_link_if link2 (.clock(clock), .rst_n(rst_n));
	wfbf_host wfbf_host_i (.clock(clock), .rst_n(rst_n), .ce(1'b1), .link(link),
		.field_go(field_go), .end_go(end_go), .timecode(h_tc), .blk_bw(h_bw), .blk_empty(h_empty),
		.data_word(h_data), .data_valid(h_valid), .data_last(h_last), .data_ready(data_ready),
		.cur_block(cur_block), .busy(busy), .next_field_two(next_field_two));
	wfbf_dev wfbf_dev_i (.clock(clock), .rst_n(rst_n), .ce(1'b1), .link(link),
		.dec_restart(dec_restart), .field_start(field_start), .field_two(field_two),
		.field_done(field_done), .seq_end(seq_end), .timecode(d_tc), .tc_valid(tc_valid),
		.blk_start(blk_start), .blk_num(blk_num), .blk_bw(d_bw), .blk_empty(d_empty),
		.data_word(d_data), .data_valid(d_valid), .frame_err(frame_err));
	wfbf_dev wfbf_dev_i2 (.clock(clock), .rst_n(rst_n), .ce(1'b1), .link(link2),
		.dec_restart(rst2), .field_start(), .field_two(), .field_done(), .seq_end(),
		.timecode(), .tc_valid(), .blk_start(), .blk_num(), .blk_bw(), .blk_empty(),
		.data_word(), .data_valid(), .frame_err(err2));
	wfbf_checker wfbf_checker_i (.clock(clock), .rst_n(rst_n), .word(link.word),
		.valid(link.valid), .ready(link.ready));

	// ========================================
	// Helpers
	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	function automatic logic [15:0] bw_of(input logic [5:0] b);
		return base[15:0] ^ {b, b, 4'h0};
	endfunction

	// Roughly one block in eight is sent empty; the first block never is
	function automatic logic em_of(input logic [5:0] b);
		return b != 6'h06 && b[2:0] == base[18:16];
	endfunction

	task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// One field (fld=1) or end code (fld=0), then wait for the host to go idle
	task automatic go(input logic fld);
		@(posedge clock);
		chk(next_field_two, hx);
		base <= rnd();
		h_tc <= 90'({rnd(), rnd(), rnd()});
		field_go <= fld;
		end_go <= !fld;
		@(posedge clock);
		field_go <= 1'b0;
		end_go <= 1'b0;
		tc_exp = h_tc;
		hx = fld && !hx;
		k = 0;
		do
		begin
			@(posedge clock);
			k++;
		end
		while (busy && k < 4000);
		chk(busy, 1'b0);
		// Both a field and an end code leave the host naming the last block
		chk(cur_block, 6'h03);
	endtask

	// ========================================
	// Coded data source; header inputs follow cur_block
	always @(posedge clock)
	begin
		h_bw <= bw_of(cur_block);
		h_empty <= em_of(cur_block);
		if (rst_n && (!h_valid || data_ready))
		begin
			if (h_valid)
				sent.push_back(h_data);
			r = rnd();
			h_data <= {1'b0, r[30:0]};
			h_last <= r[31] | r[30];
			h_valid <= 1'b1;
		end
	end

	// ========================================
	// Device output monitor
	always @(posedge clock)
	if (rst_n)
	begin
		if (field_done)
		begin
			chk(idx, 42);
			n_done++;
		end
		if (seq_end)
		begin
			two_exp = 1'b0;
			n_end++;
		end
		if (field_start)
		begin
			chk(field_two, two_exp);
			chk(dec_restart, !two_exp);
			two_exp = !two_exp;
			idx = 0;
		end
		if (tc_valid)
			chk(d_tc, tc_exp);
		if (blk_start)
		begin
			n = NUMS[(41 - idx) * 8 +: 6];
			empty_exp = em_of(n);
			chk({blk_num, d_bw, d_empty}, {n, bw_of(n), empty_exp});
			idx++;
		end
		if (d_valid)
		begin
			chk(empty_exp, 1'b0);
			chk(d_data, sent.pop_front());
		end
		chk(frame_err, 1'b0);
		n_err2 += int'(err2);
		n_rst2 += int'(rst2);
	end

	// ========================================
	// Main sequence
	initial
	begin
		link2.word = 32'h00000000;
		link2.valid = 1'b0;
		repeat (2) @(posedge clock);
		rst_n <= 1'b1;
		// Three fields, end, two fields, end: the end must restart at field one
		for (int f = 0; f < 7; f++)
			go(f != 3 && f != 6);
		repeat (8) @(posedge clock);
		chk(n_done, 5);
		chk(n_end, 2);
		chk(sent.size(), 0);
		foreach (bad[i])
		begin
			link2.word <= bad[i];
			link2.valid <= 1'b1;
			@(posedge clock);
		end
		link2.valid <= 1'b0;
		link2.word <= ~bad[3];
		repeat (4) @(posedge clock);
		chk(n_err2, 1);
		chk(n_rst2, 1);
		summarize();
	end

	// Watchdog: the whole run needs a little over a thousand cycles
	initial
	begin
		repeat (30000) @(posedge clock);
		errors++;
		summarize();
	end
endmodule
